// ### rtl/ppi_unit.sv
// polled input pattern interrupt unit
//
// What this block does
// - check inputs between every two consecutive instructions.
// - during melody playback, check between successive notes.
// - during delay instructions, check every cycle of the delay.
// - on armed match, request an immediate call to the handler.
// - inputs ANDed with mask; masked-off bits never matter.
// - match only when masked inputs equal compare byte exactly.
// - bit n of mask and compare maps to input n.
// - arming supplies compare byte then mask byte; both latched.
// - one pattern held; new arming replaces the old.
// - arming with zero mask disables the interrupt.
// - taking the interrupt disarms the unit.
// - arming inside the handler takes effect at handler return.
// - re-armed with condition still true, interrupt can fire on return.
// - after return, resume at next main-program instruction.
// - interrupted delay or playback drops its remaining time.
`timescale 1ns/1ps
`include "ppi_defines.svh"

module ppi_unit #(
   parameter int PORT_W = `PPI_PORT_W
) (
   input  wire logic                 clk,
   input  wire logic                 resetn,
   input  wire logic [PORT_W-1:0]    in_pins,
   input  wire logic                 arm_valid,
   input  wire ppi_pkg::ppi_pattern_t arm_pattern,
   input  wire ppi_pkg::ppi_seq_t    seq,
   output logic                      irq_call,
   output logic                      abort_delay,
   output logic                      skip_to_next,
   output logic                      armed,
   output logic                      in_handler
);

   // the match function and the pattern struct are fixed at one byte
   if (PORT_W != 8) begin : g_port_w_check
      $error("ppi_unit supports an 8-bit input port only");
   end

   ppi_pkg::ppi_pattern_t pat, next_pat;
   ppi_pkg::ppi_pattern_t pend_pat, next_pend_pat;
   logic                  pend, next_pend;
   logic                  next_armed;
   ppi_pkg::ppi_state_t   state, next_state;
   logic                  next_irq_call;
   logic                  next_abort_delay;
   logic                  next_skip;
   logic                  next_in_handler;
   logic                  match;
   logic                  poll;

   function automatic logic ppi_match(input logic [7:0] pins, input ppi_pkg::ppi_pattern_t p);
      ppi_match = ((pins & p.mask) == p.cmp);
   endfunction : ppi_match

   always_comb begin
      // poll points: instruction gap, note gap, every delay cycle
      poll  = seq.check_gap | seq.check_note | seq.in_delay;
      match = ppi_match(in_pins, pat);
      next_pat         = pat;
      next_pend_pat    = pend_pat;
      next_pend        = pend;
      next_armed       = armed;
      next_state       = state;
      next_irq_call    = 1'b0;
      next_abort_delay = 1'b0;
      next_skip        = 1'b0;
      next_in_handler  = in_handler;
      unique case (state)
         ppi_pkg::PPI_IDLE: begin
            if (arm_valid) begin
               next_pat   = arm_pattern;
               next_armed = (arm_pattern.mask != `PPI_MASK_OFF);
            end else if (armed && poll && match) begin
               next_irq_call    = 1'b1;
               next_armed       = 1'b0;
               next_abort_delay = seq.in_delay | seq.check_note;
               next_state       = ppi_pkg::PPI_HANDLER;
               next_in_handler  = 1'b1;
            end
         end
         ppi_pkg::PPI_HANDLER: begin
            if (arm_valid) begin
               next_pend_pat = arm_pattern;
               next_pend     = 1'b1;
            end
            if (seq.handler_ret) begin
               next_skip       = 1'b1;
               next_state      = ppi_pkg::PPI_IDLE;
               next_in_handler = 1'b0;
               if (next_pend) begin
                  next_pat   = arm_valid ? arm_pattern : pend_pat;
                  // armed now, so a still-true condition fires at the next poll
                  next_armed = (next_pat.mask != `PPI_MASK_OFF);
               end
               next_pend = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pat.cmp       <= `PPI_CMP_RESET;
         pat.mask      <= `PPI_MASK_RESET;
         pend_pat.cmp  <= `PPI_CMP_RESET;
         pend_pat.mask <= `PPI_MASK_RESET;
         pend          <= 1'b0;
         armed         <= 1'b0;
         state         <= ppi_pkg::PPI_IDLE;
         irq_call      <= 1'b0;
         abort_delay   <= 1'b0;
         skip_to_next  <= 1'b0;
         in_handler    <= 1'b0;
      end else begin
         pat          <= next_pat;
         pend_pat     <= next_pend_pat;
         pend         <= next_pend;
         armed        <= next_armed;
         state        <= next_state;
         irq_call     <= next_irq_call;
         abort_delay  <= next_abort_delay;
         skip_to_next <= next_skip;
         in_handler   <= next_in_handler;
      end
   end

endmodule : ppi_unit

// ### pkg/ppi_defines.svh
// constants for the polled input pattern interrupt unit
`ifndef PPI_DEFINES_SVH
`define PPI_DEFINES_SVH
`define PPI_PORT_W        8
`define PPI_CMP_RESET     8'h00
`define PPI_MASK_RESET    8'h00
`define PPI_MASK_OFF      8'h00
`endif

// ### pkg/ppi_pkg.sv
// types for the polled input pattern interrupt unit
package ppi_pkg;
   typedef struct packed {
      logic [7:0] cmp;
      logic [7:0] mask;
   } ppi_pattern_t;

   typedef struct packed {
      logic check_gap;
      logic check_note;
      logic in_delay;
      logic in_handler;
      logic handler_ret;
   } ppi_seq_t;

   typedef enum logic [1:0] {
      PPI_IDLE    = 2'b01,
      PPI_HANDLER = 2'b10
   } ppi_state_t;
endpackage : ppi_pkg

// ### verif/ppi_chk.sv
// assertions on the pattern interrupt unit outputs
`timescale 1ns/1ps
module ppi_chk (
   input wire logic              clk,
   input wire logic              resetn,
   input wire ppi_pkg::ppi_seq_t seq,
   input wire logic              irq_call,
   input wire logic              abort_delay,
   input wire logic              skip_to_next,
   input wire logic              armed,
   input wire logic              in_handler
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_ret; in_handler && seq.handler_ret; endsequence
   take_state_a: assert property (irq_call |-> in_handler && !armed) else $error("take state");
   quiet_idle_a: assert property (!armed || in_handler |=> !irq_call) else $error("call while idle");
   abort_src_a: assert property (irq_call |-> abort_delay == ($past(seq.in_delay) || $past(seq.check_note)))
      else $error("abort source");
   abort_only_a: assert property (abort_delay |-> irq_call) else $error("abort alone");
   call_pulse_a: assert property (irq_call |=> !irq_call) else $error("long call");
   defer_arm_a: assert property (in_handler && !seq.handler_ret |=> !armed) else $error("early arm");
   resume_main_a: assert property (s_ret |=> skip_to_next && !in_handler) else $error("no resume");
   skip_src_a: assert property (skip_to_next |-> $past(seq.handler_ret) && $past(in_handler)) else $error("skip");
endmodule : ppi_chk
bind ppi_unit ppi_chk u_ppi_chk (.clk, .resetn, .seq, .irq_call, .abort_delay, .skip_to_next, .armed, .in_handler);

// ### verif/ppi_seq_model.sv
// sequencer model: raises ret wait_n+1 cycles after irq_call, ending the handler
`timescale 1ns/1ps
module ppi_seq_model (
   input  wire logic clk,
   input  wire logic irq_call,
   output logic      ret
);
   logic       busy = 1'b0;
   logic [7:0] n, wait_n = 8'h00;
   initial ret = 1'b0;
   always @(posedge clk) begin
      #1 ret = busy && n == 8'h00;
      busy = irq_call || (busy && !ret);
      n = irq_call ? wait_n : n - 8'h01;
   end
endmodule : ppi_seq_model

// ### verif/polled_input_pattern_interrupt_test.sv
// self-checking bench for the pattern interrupt unit
`timescale 1ns/1ps
module polled_input_pattern_interrupt_test;
   logic clk = 1'b0, resetn = 1'b0, arm_valid = 1'b0, gap = 1'b0, note = 1'b0, dly = 1'b0, ret;
   logic [7:0] in_pins = 8'h00;
   wire  [4:0] o;
   ppi_pkg::ppi_pattern_t pat = 16'h0000;
   int fails, checks, cyc;
   ppi_unit u_ppi_unit (.clk, .resetn, .in_pins, .arm_valid, .arm_pattern(pat), .seq({gap, note, dly, o[0], ret}),
      .irq_call(o[4]), .abort_delay(o[3]), .skip_to_next(o[2]), .armed(o[1]), .in_handler(o[0]));
   ppi_seq_model u_ppi_seq_model (.clk, .irq_call(o[4]), .ret);
   initial forever #5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   always @(posedge clk) if (cyc == 200) end_of_test();
   task automatic check(string name, logic [4:0] seen, logic [4:0] exp);
      checks++;
      fails += int'(seen !== exp);
      if (seen !== exp) $display("wrong value %s expected %h seen %h", name, exp, seen);
   endtask : check
   task automatic arm(ppi_pkg::ppi_pattern_t p);
      {arm_valid, pat} = {1'b1, p};
      #10 arm_valid = 1'b0;
   endtask : arm
   task automatic gap_and_note();
      arm(16'hFFFF);
      #10 arm(16'h0103);
      {in_pins, gap} = {8'hFF, 1'b1};
      #10 check("miss", o, 5'h02);
      in_pins = 8'hFD;
      #10 check("gap", o, 5'h11);
      {gap, note} = 2'b01;
      #20 check("ret", o, 5'h04);
      arm(16'h4040);
      #10 check("note", o, 5'h19);
      note = 1'b0;
      #20 arm(16'h4040);
      #10 arm(16'h0000);
      gap = 1'b1;
      #20 check("off", o, 5'h00);
      gap = 1'b0;
   endtask : gap_and_note
   task automatic delay_rearm();
      u_ppi_seq_model.wait_n = 8'h05;
      arm(16'h8080);
      {in_pins, dly} = {8'h00, 1'b1};
      #30 check("hold", o, 5'h02);
      in_pins = 8'h80;
      #10 check("dly", o, 5'h19);
      {dly, gap} = 2'b01;
      arm(16'h8080);
      check("defer", o, 5'h01);
      #60 check("back", o, 5'h06);
      #10 check("again", o, 5'h11);
   endtask : delay_rearm
   task automatic end_of_test();
      fails += int'(cyc >= 200);
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_of_test
   initial begin
      #196 resetn = 1'b1;
      check("reset", o, 5'h00);
      gap_and_note();
      delay_rearm();
      end_of_test();
   end
endmodule : polled_input_pattern_interrupt_test
